// >>> logic/hbfr_ctrl.sv
// Operation
// - One byte config register, read/write, resets zero
// - Four 2-bit fields: OV out, UV out, OV in, UV in
// - Override bit picks fields, else mode pin code
// - Output overvoltage sets status bit 4, flag low
// - Output undervoltage sets status bit 5, flag low
// - Hiccup stops switching, resumes 500ms after clear
// - Latch-off holds stop until either enable pin toggles
// - Input overvoltage sets status bit 6, flag low
// - Input undervoltage sets status bit 7, flag low
`timescale 1ns/1ps
`default_nettype none
module hbfr_ctrl #(
  parameter int                      HICCUP_CNT_W  = hbfr_pkg::HICCUP_CNT_W,
  parameter logic [HICCUP_CNT_W-1:0] HICCUP_CYCLES = HICCUP_CNT_W'(hbfr_pkg::HICCUP_CYCLES)
) (
  input  wire logic                       clock,
  input  wire logic                       reset_n,
  input  wire hbfr_pkg::hbfr_reg_req_type reg_req,
  output logic [7:0]                      reg_rd_data,
  input  wire logic                       individual_response_en,
  input  wire logic [1:0]                 mode_pin_code,
  input  wire hbfr_pkg::hbfr_fault_type   faults,
  input  wire logic                       pwm_en_pin,
  input  wire logic                       en_pin,
  output logic                            pwm_switch_allow,
  output logic                            fault_status_out_n
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [7:0] cfg;
    logic [3:0] status;
    logic [7:0] rd_data;
    logic [1:0] mode_s1;
    logic [1:0] mode_s2;
    logic       pwm_s1;
    logic       pwm_s2;
    logic       pwm_d;
    logic       en_s1;
    logic       en_s2;
    logic       en_d;
    logic       allow;
    logic       flag_n;
  } hbfr_ctrl_state_type;

  localparam hbfr_ctrl_state_type ST_RESET = '{
    cfg:     hbfr_pkg::CFG_RESET,
    status:  hbfr_pkg::STATUS_RESET,
    rd_data: hbfr_pkg::UNMAPPED_RD,
    allow:   1'b1,
    flag_n:  1'b1,
    default: '0
  };

  hbfr_ctrl_state_type st_reg;
  hbfr_ctrl_state_type st_next;

  logic [3:0]      fault_vec;
  logic [3:0][1:0] eff_code;
  logic [3:0]      stop;
  logic [3:0]      status_clr;
  logic            restart;
  logic            cfg_wr;
  logic            status_wr;

  // Comparator results already live on this clock
  assign fault_vec = faults;

  // ==========================================================================
  // Decode and pin events
  // ==========================================================================
  assign cfg_wr    = reg_req.wr_en && (reg_req.addr == hbfr_pkg::CFG_ADDR);
  assign status_wr = reg_req.wr_en && (reg_req.addr == hbfr_pkg::STATUS_ADDR);
  // Write one to clear; a fault in the same cycle still sets
  assign status_clr = status_wr ? reg_req.wr_data[hbfr_pkg::STATUS_LSB +: 4] : 4'h0;
  // Any change of either enable pin releases a latch-off
  assign restart = (st_reg.pwm_s2 ^ st_reg.pwm_d) | (st_reg.en_s2 ^ st_reg.en_d);

  // Pick per-fault field or the pin-wide setting
  always_comb begin
    for (int i = 0; i < hbfr_pkg::FAULT_COUNT; i++) begin
      if (individual_response_en) begin
        eff_code[i] = hbfr_pkg::hbfr_field(st_reg.cfg, i);
      end else begin
        eff_code[i] = st_reg.mode_s2;
      end
    end
  end

  // ==========================================================================
  // Per-fault responders
  // ==========================================================================
  // Flag-only codes decode to RESP_FLAG and never stop switching
  for (genvar g = 0; g < hbfr_pkg::FAULT_COUNT; g++) begin : g_rsp
    hbfr_responder #(
      .CNT_W       (HICCUP_CNT_W),
      .HOLD_CYCLES (HICCUP_CYCLES)
    ) u_rsp (
      .clock   (clock),
      .reset_n (reset_n),
      .fault   (fault_vec[g]),
      .resp    (hbfr_pkg::hbfr_decode(eff_code[g])),
      .restart (restart),
      .stop    (stop[g])
    );
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    st_next = st_reg;
    // Two-flop synchronisers; the first stage feeds only the second
    st_next.mode_s1 = mode_pin_code;
    st_next.mode_s2 = st_reg.mode_s1;
    st_next.pwm_s1  = pwm_en_pin;
    st_next.pwm_s2  = st_reg.pwm_s1;
    st_next.pwm_d   = st_reg.pwm_s2;
    st_next.en_s1   = en_pin;
    st_next.en_s2   = st_reg.en_s1;
    st_next.en_d    = st_reg.en_s2;
    // Every bit writable
    if (cfg_wr) begin
      st_next.cfg = reg_req.wr_data;
    end
    // Sticky status, set wins over clear, under every code
    st_next.status = (st_reg.status & ~status_clr) | fault_vec;
    st_next.flag_n = ~|st_next.status;
    st_next.allow  = ~|stop;
    // Read answer one cycle after the address
    unique case (reg_req.addr)
      hbfr_pkg::CFG_ADDR:    st_next.rd_data = st_reg.cfg;
      hbfr_pkg::STATUS_ADDR: st_next.rd_data = {st_reg.status, 4'h0};
      default:               st_next.rd_data = hbfr_pkg::UNMAPPED_RD;
    endcase
  end

  // Register the whole state
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rd_data        = st_reg.rd_data;
  assign pwm_switch_allow   = st_reg.allow;
  assign fault_status_out_n = st_reg.flag_n;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  property p_cfg_reset;
    $rose(reset_n) |-> (st_reg.cfg == hbfr_pkg::CFG_RESET);
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("config not zero after reset");

  property p_cfg_rw;
    cfg_wr |=> (st_reg.cfg == $past(reg_req.wr_data)) ##1
      ($past(reg_req.addr) != hbfr_pkg::CFG_ADDR || reg_rd_data == $past(st_reg.cfg));
  endproperty
  a_cfg_rw: assert property (p_cfg_rw) else $error("config write or read wrong");

  property p_field_map;
    individual_response_en |-> (eff_code[1] == st_reg.cfg[3:2]) &&
      (eff_code[0] == st_reg.cfg[1:0]) && (eff_code[3] == st_reg.cfg[7:6]);
  endproperty
  a_field_map: assert property (p_field_map) else $error("field map wrong");

  property p_mode_pin;
    !individual_response_en |-> (eff_code == {4{st_reg.mode_s2}});
  endproperty
  a_mode_pin: assert property (p_mode_pin) else $error("mode pin code not used");

  property p_flag_only;
    (individual_response_en && st_reg.cfg == 8'hff && stop == 4'h0)[*2]
      |=> pwm_switch_allow;
  endproperty
  a_flag_only: assert property (p_flag_only) else $error("flag only stopped switching");

  property p_ov_out;
    faults.ov_out |=> st_reg.status[hbfr_pkg::FAULT_OV_OUT] && !fault_status_out_n;
  endproperty
  a_ov_out: assert property (p_ov_out) else $error("output OV not flagged");

  property p_uv_out;
    faults.uv_out |=> st_reg.status[hbfr_pkg::FAULT_UV_OUT] && !fault_status_out_n;
  endproperty
  a_uv_out: assert property (p_uv_out) else $error("output UV not flagged");

  property p_ov_in;
    faults.ov_in |=> st_reg.status[hbfr_pkg::FAULT_OV_IN] ##0 !fault_status_out_n;
  endproperty
  a_ov_in: assert property (p_ov_in) else $error("input OV not flagged");

  property p_uv_in;
    faults.uv_in |=> st_reg.status[hbfr_pkg::FAULT_UV_IN] && !fault_status_out_n;
  endproperty
  a_uv_in: assert property (p_uv_in) else $error("input UV not flagged");

  property p_stop_out;
    (|stop) |=> !pwm_switch_allow;
  endproperty
  a_stop_out: assert property (p_stop_out) else $error("switching not stopped");

  // A flag-only code on output OV must never start a stop, fault or not
  property p_flag_keeps_run;
    (hbfr_pkg::hbfr_decode(eff_code[0]) == hbfr_pkg::RESP_FLAG && !stop[0]) |=> !stop[0];
  endproperty
  a_flag_keeps_run: assert property (p_flag_keeps_run) else $error("flag only code stopped");

  c_flag:    cover property (fault_status_out_n ##1 !fault_status_out_n);
  c_latch:   cover property (individual_response_en && eff_code[0] == hbfr_pkg::CODE_LATCH
                             ##1 !pwm_switch_allow ##[1:20] pwm_switch_allow);
  c_w1c:     cover property (status_wr && st_reg.status != 4'h0 ##1 st_reg.status == 4'h0);

endmodule : hbfr_ctrl
`default_nettype wire

// >>> logic/hbfr_pkg.sv
`default_nettype none
package hbfr_pkg;

  // ==========================================================================
  // Register map and reset values
  // ==========================================================================
  localparam logic [7:0] CFG_ADDR     = 8'hb2;
  localparam logic [7:0] STATUS_ADDR  = 8'hd2;
  localparam logic [7:0] CFG_RESET    = 8'h00;
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam logic [7:0] UNMAPPED_RD  = 8'h00;

  // ==========================================================================
  // Field layout
  // ==========================================================================
  localparam int FAULT_COUNT = 4;   // Output OV, output UV, input OV, input UV
  localparam int FIELD_W     = 2;   // Field of fault i sits at bits 2i+1:2i
  localparam int STATUS_LSB  = 4;   // Status bit of fault i is bit 4+i
  localparam int FAULT_OV_OUT = 0;
  localparam int FAULT_UV_OUT = 1;
  localparam int FAULT_OV_IN  = 2;
  localparam int FAULT_UV_IN  = 3;

  // Response codes
  localparam logic [1:0] CODE_FLAG     = 2'h0;
  localparam logic [1:0] CODE_HICCUP   = 2'h1;
  localparam logic [1:0] CODE_LATCH    = 2'h2;
  localparam logic [1:0] CODE_FLAG_ALT = 2'h3;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int HICCUP_TIME_MS = 500;
  localparam int CLOCK_KHZ      = 125000;
  localparam int HICCUP_CYCLES  = HICCUP_TIME_MS * CLOCK_KHZ;
  localparam int HICCUP_CNT_W   = 26;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {RESP_FLAG, RESP_HICCUP, RESP_LATCH} hbfr_resp_type;

  typedef enum logic [1:0] {RSP_RUN, RSP_WAIT, RSP_LATCHED} hbfr_rsp_state_type;

  typedef struct packed {
    logic       wr_en;
    logic [7:0] addr;
    logic [7:0] wr_data;
  } hbfr_reg_req_type;

  // Bit 0 is output OV, matching the field order
  typedef struct packed {
    logic uv_in;
    logic ov_in;
    logic uv_out;
    logic ov_out;
  } hbfr_fault_type;

  // Codes 00 and 11 both mean flag only
  function automatic hbfr_resp_type hbfr_decode(input logic [1:0] code);
    case (code)
      CODE_HICCUP: return RESP_HICCUP;
      CODE_LATCH:  return RESP_LATCH;
      default:     return RESP_FLAG;
    endcase
  endfunction : hbfr_decode

  function automatic logic [1:0] hbfr_field(input logic [7:0] cfg, input int idx);
    return cfg[idx*FIELD_W +: FIELD_W];
  endfunction : hbfr_field

endpackage : hbfr_pkg
`default_nettype wire

// >>> logic/hbfr_responder.sv
`timescale 1ns/1ps
`default_nettype none
module hbfr_responder #(
  parameter int                 CNT_W       = hbfr_pkg::HICCUP_CNT_W,
  parameter logic [CNT_W-1:0]   HOLD_CYCLES = CNT_W'(hbfr_pkg::HICCUP_CYCLES)
) (
  input  wire logic                    clock,
  input  wire logic                    reset_n,
  input  wire logic                    fault,
  input  wire hbfr_pkg::hbfr_resp_type resp,
  input  wire logic                    restart,
  output logic                         stop
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    hbfr_pkg::hbfr_rsp_state_type state;
    logic [CNT_W-1:0]             count;
    logic                         stop;
  } hbfr_rsp_type;

  localparam logic [CNT_W-1:0] LAST = HOLD_CYCLES - CNT_W'(1);
  localparam hbfr_rsp_type RSP_RESET = '{state: hbfr_pkg::RSP_RUN, default: '0};

  hbfr_rsp_type st_reg;
  hbfr_rsp_type st_next;

  // ==========================================================================
  // Response sequencing
  // ==========================================================================
  // Flag-only faults never leave RUN; status is handled above
  always_comb begin
    st_next = st_reg;
    unique case (st_reg.state)
      hbfr_pkg::RSP_RUN: begin
        if (fault && resp == hbfr_pkg::RESP_HICCUP) begin
          st_next.state = hbfr_pkg::RSP_WAIT;
          st_next.count = '0;
        end else if (fault && resp == hbfr_pkg::RESP_LATCH) begin
          st_next.state = hbfr_pkg::RSP_LATCHED;
        end
      end
      hbfr_pkg::RSP_WAIT: begin
        if (fault && resp == hbfr_pkg::RESP_LATCH) begin
          st_next.state = hbfr_pkg::RSP_LATCHED;
          st_next.count = '0; // Fresh count, as for any refault
        end else if (fault) begin
          st_next.count = '0;
        end else if (st_reg.count >= LAST) begin
          st_next.state = hbfr_pkg::RSP_RUN;
        end else begin
          st_next.count = st_reg.count + CNT_W'(1);
        end
      end
      hbfr_pkg::RSP_LATCHED: begin
        if (restart) begin
          st_next.state = hbfr_pkg::RSP_RUN;
        end
      end
    endcase
    st_next.stop = (st_next.state != hbfr_pkg::RSP_RUN);
  end

  // Register the whole state
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      st_reg <= RSP_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign stop = st_reg.stop;

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_hiccup_stop;
    @(posedge clock) disable iff (!reset_n)
    (!stop && fault && resp == hbfr_pkg::RESP_HICCUP) |=> stop ##0 (st_reg.count == '0);
  endproperty
  a_hiccup_stop: assert property (p_hiccup_stop) else $error("hiccup did not stop");

  property p_hiccup_end;
    @(posedge clock) disable iff (!reset_n)
    (st_reg.state == hbfr_pkg::RSP_WAIT && !fault && st_reg.count == LAST
     && resp != hbfr_pkg::RESP_LATCH) |=> !stop;
  endproperty
  a_hiccup_end: assert property (p_hiccup_end) else $error("hiccup did not resume");

  property p_wait_restart;
    @(posedge clock) disable iff (!reset_n)
    (st_reg.state == hbfr_pkg::RSP_WAIT && fault) |=> (st_reg.count == '0) && stop;
  endproperty
  a_wait_restart: assert property (p_wait_restart) else $error("delay not restarted");

  property p_latch_hold;
    @(posedge clock) disable iff (!reset_n)
    (st_reg.state == hbfr_pkg::RSP_LATCHED && !restart) |=> stop;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch-off released");

  c_hiccup_end: cover property (@(posedge clock) disable iff (!reset_n) $fell(stop));

endmodule : hbfr_responder
`default_nettype wire

// >>> test/hbfr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Host side: owns the two enable pins and restarts a latched converter
// ============================================================================
module hbfr_host_model (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic toggle,
  input  wire logic use_en_pin,
  output logic      pwm_en_pin,
  output logic      en_pin
);
  // One pin flips per request; the flip is the only way out of latch-off
  always @(posedge clock) begin
    if (!reset_n) begin
      // Pins rest low like the synchronisers, so no spurious restart edge
      pwm_en_pin <= 1'b0;
      en_pin     <= 1'b0;
    end else if (toggle) begin
      if (use_en_pin) begin
        en_pin <= ~en_pin;
      end else begin
        pwm_en_pin <= ~pwm_en_pin;
      end
    end
  end
endmodule : hbfr_host_model
`default_nettype wire

// >>> test/test_hbfr_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`define HBFR_CHK(got, exp) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("wrong value at %0t ns: got %h expected %h", $time, (got), (exp)); \
  end \
end
module test_hbfr_ctrl;
  // Short hiccup count keeps the run brief
  localparam int HC = 16;

  logic                       clock;
  logic                       reset_n;
  hbfr_pkg::hbfr_reg_req_type reg_req;
  logic [7:0]                 reg_rd_data;
  logic                       individual_response_en;
  logic [1:0]                 mode_pin_code;
  hbfr_pkg::hbfr_fault_type   faults;
  logic                       pwm_en_pin;
  logic                       en_pin;
  logic                       pwm_switch_allow;
  logic                       fault_status_out_n;
  logic                       toggle;
  logic                       use_en_pin;
  int                         num_errors;
  int                         cmp_count;
  logic [7:0]                 pats [4] = '{8'ha5, 8'h5a, 8'hff, 8'h00};

  hbfr_ctrl #(.HICCUP_CNT_W(26), .HICCUP_CYCLES(26'(HC))) dut (
    .clock(clock), .reset_n(reset_n), .reg_req(reg_req), .reg_rd_data(reg_rd_data),
    .individual_response_en(individual_response_en), .mode_pin_code(mode_pin_code),
    .faults(faults), .pwm_en_pin(pwm_en_pin), .en_pin(en_pin),
    .pwm_switch_allow(pwm_switch_allow), .fault_status_out_n(fault_status_out_n)
  );

  hbfr_host_model host (
    .clock(clock), .reset_n(reset_n), .toggle(toggle), .use_en_pin(use_en_pin),
    .pwm_en_pin(pwm_en_pin), .en_pin(en_pin)
  );

  // ==========================================================================
  // Clock and closing report
  // ==========================================================================
  initial clock = 1'b0;
  always #4 clock = ~clock;

  task automatic give_verdict();
    $display("mismatches %0d, comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  // ==========================================================================
  // Register access: every task starts and ends 1 ns after a rising edge
  // ==========================================================================
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_req = '{wr_en: 1'b1, addr: a, wr_data: d};
    @(posedge clock);
    #1 reg_req.wr_en = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_req.addr = a;
    @(posedge clock);
    #1 `HBFR_CHK(reg_rd_data, e)
  endtask : rd

  // Waits for switching to come back, up to bound cycles; n returns the cycles waited and the caller judges it
  task automatic wait_allow(input int bound, output int n);
    n = 0;
    while (pwm_switch_allow !== 1'b1 && n < bound) begin
      @(posedge clock);
      #1 n++;
    end
  endtask : wait_allow

  // ==========================================================================
  // One fault event under one effective response code
  // ==========================================================================
  task automatic run_resp(input int i, input logic [1:0] code);
    int n;
    faults = hbfr_pkg::hbfr_fault_type'(4'h1 << i);
    @(posedge clock);
    #1 `HBFR_CHK(fault_status_out_n, 1'b0)
    @(posedge clock);
    #1 `HBFR_CHK(pwm_switch_allow, (code == 2'h1 || code == 2'h2) ? 1'b0 : 1'b1)
    faults = '0;
    // Refault halfway through the wait must restart the count
    if (code == hbfr_pkg::CODE_HICCUP) begin
      repeat (HC / 2) @(posedge clock);
      #1 faults = hbfr_pkg::hbfr_fault_type'(4'h1 << i);
      @(posedge clock);
      #1 faults = '0;
    end
    wait_allow(4 * HC, n);
    case (code)
      hbfr_pkg::CODE_HICCUP: begin
        `HBFR_CHK(n >= HC && n <= HC + 4, 1'b1)
        if (n == 4 * HC) give_verdict();
      end
      hbfr_pkg::CODE_LATCH: begin
        `HBFR_CHK(n, 4 * HC)
        use_en_pin = i[0];
        toggle = 1'b1;
        @(posedge clock);
        #1 toggle = 1'b0;
        wait_allow(12, n);
        `HBFR_CHK(pwm_switch_allow, 1'b1)
        if (n == 12) give_verdict();
      end
      default: `HBFR_CHK(n, 0)
    endcase
    // Status stays set until cleared with the fault gone
    rd(hbfr_pkg::STATUS_ADDR, 8'h10 << i);
    wr(hbfr_pkg::STATUS_ADDR, 8'hf0);
    rd(hbfr_pkg::STATUS_ADDR, 8'h00);
    `HBFR_CHK(fault_status_out_n, 1'b1)
  endtask : run_resp

  // Hard stop in case a wait hangs outside the bounded loops
  initial begin
    #400000;
    num_errors++;
    give_verdict();
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    num_errors = 0;
    cmp_count = 0;
    reset_n = 1'b0;
    reg_req = '0;
    individual_response_en = 1'b1;
    mode_pin_code = 2'h0;
    faults = '0;
    toggle = 1'b0;
    use_en_pin = 1'b0;
    repeat (4) @(posedge clock);
    #1 reset_n = 1'b1;
    `HBFR_CHK(fault_status_out_n, 1'b1)
    `HBFR_CHK(pwm_switch_allow, 1'b1)
    rd(hbfr_pkg::CFG_ADDR, 8'h00);
    rd(hbfr_pkg::STATUS_ADDR, 8'h00);
    // Every bit writable and readable back
    foreach (pats[k]) begin
      wr(hbfr_pkg::CFG_ADDR, pats[k]);
      rd(hbfr_pkg::CFG_ADDR, pats[k]);
    end
    // Unmapped place reads zero and does not alias the config byte
    wr(8'hb3, 8'h55);
    rd(8'hb3, 8'h00);
    rd(hbfr_pkg::CFG_ADDR, 8'h00);
    // Every fault through every code, field placed at bits 2i+1:2i
    for (int i = 0; i < 4; i++) begin
      for (int c = 0; c < 4; c++) begin
        wr(hbfr_pkg::CFG_ADDR, 8'(c) << (2 * i));
        run_resp(i, 2'(c));
      end
    end
    // Override off: the pin code rules and the fields are ignored
    individual_response_en = 1'b0;
    wr(hbfr_pkg::CFG_ADDR, 8'h55);
    repeat (4) @(posedge clock);
    #1 run_resp(0, 2'h0);
    mode_pin_code = 2'h2;
    wr(hbfr_pkg::CFG_ADDR, 8'h00);
    repeat (4) @(posedge clock);
    #1 run_resp(1, 2'h2);
    // Pin-wide hiccup, fields all flag-only
    mode_pin_code = 2'h1;
    repeat (4) @(posedge clock);
    #1 run_resp(2, 2'h1);
    give_verdict();
  end
endmodule : test_hbfr_ctrl
`default_nettype wire
